/* rtl/rx_status_defines.svh */
// Addresses, field positions and default widths of the receiver status readout
`ifndef RX_STATUS_DEFINES_SVH
`define RX_STATUS_DEFINES_SVH

`define ADDR_W 7
`define DATA_W 8
`define BYTE_ZERO 8'h00

`define ADDR_RATIO_HIGH 7'h12
`define ADDR_RATIO_LOW 7'h13
`define ADDR_INFO_HIGH 7'h14
`define ADDR_INFO_LOW 7'h15
`define ADDR_LENGTH_HIGH 7'h16
`define ADDR_LENGTH_LOW 7'h17
`define ADDR_RX_ERROR 7'h18

`define RATIO_W_DEF 15
`define PREAMBLE_W_DEF 16

`define ERR_LOCK 0
`define ERR_CODING 1
`define ERR_ABSENT 2
`define ERR_CHECK 3
`define ERR_PRE_TYPE 4
`define ERR_NONAUDIO 5
`define ERR_EMPHASIS 6
`define ERR_VALIDITY 7

`endif

/* rtl/rx_status_pkg.sv */
// Types shared by the receiver status readout
package rx_status_pkg;

  typedef enum logic {
    FLAG_STICKY,
    FLAG_LEVEL
  } flag_kind_t;

endpackage : rx_status_pkg

/* rtl/rx_flag_cell.sv */
// One receiver error flag: sticky-until-read or level with change-only notification
`timescale 1ns/1ps
`include "rx_status_defines.svh"

module rx_flag_cell #(
  parameter rx_status_pkg::flag_kind_t KIND = rx_status_pkg::FLAG_LEVEL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source: event pulse for sticky, level for level kind
  input wire logic src_in,
  // Read of the error register
  input wire logic read_clear,
  // Flag value and interrupt pending
  output logic flag_ff,
  output logic pend_ff
);
  import rx_status_pkg::*;

  logic nxt_flag;
  logic nxt_pend;

  always_comb
  begin
    if (KIND == FLAG_STICKY)
    begin
      // Set wins over the read clear so no error is lost
      nxt_flag = src_in | (flag_ff & ~read_clear);
      nxt_pend = src_in | (pend_ff & ~read_clear);
    end
    else
    begin
      // Value tracks the level; only a change asks for attention again
      nxt_flag = src_in;
      nxt_pend = (src_in != flag_ff) | (pend_ff & ~read_clear);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_ff <= 1'b0;
    else
      pend_ff <= nxt_pend;
  end

endmodule : rx_flag_cell

/* rtl/digital_rx_status_readout.sv */
// Read-only status bank of the digital receiver and rate converter
//
// Contract
// - Register 0x13 reads the low eight bits of the 15-bit rate ratio.
// - Register 0x12 reads ratio bits 14..8 in bits 6..0; bit 7 reads zero.
// - On nonaudio detection, burst-info preamble readable: high 0x14, low 0x15.
// - Without nonaudio detection all preamble registers read zero.
// - On nonaudio detection, burst-length preamble readable: high 0x16, low 0x17.
// - In per-subframe mode the length pair holds channel B's burst-info preamble.
// - Error bit 3 flags check failure, held until error register is read.
// - Error bit 2 is high while no input stream is present.
// - Read absent flag keeps its level; no new interrupt until it changes.
// - Mask bit one lets same-position flag interrupt; zero blocks it.
`timescale 1ns/1ps
`include "rx_status_defines.svh"

module digital_rx_status_readout #(
  parameter int RATIO_W = `RATIO_W_DEF,
  parameter int PREAMBLE_W = `PREAMBLE_W_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register read port of the control serial port
  input wire logic rd_req,
  input wire logic [`ADDR_W-1:0] rd_addr,
  output logic [`DATA_W-1:0] rd_data_ff,
  output logic rd_ack_ff,
  // Rate converter measurement
  input wire logic [RATIO_W-1:0] rate_ratio,
  // Burst preamble capture
  input wire logic nonaudio_detected,
  input wire logic subframe_mode,
  input wire logic burst_c_valid,
  input wire logic [PREAMBLE_W-1:0] burst_c_word,
  input wire logic burst_d_valid,
  input wire logic [PREAMBLE_W-1:0] burst_d_word,
  input wire logic chb_c_valid,
  input wire logic [PREAMBLE_W-1:0] chb_c_word,
  // Receiver condition sources
  input wire logic lock_level,
  input wire logic coding_error_pulse,
  input wire logic stream_absent_flag,
  input wire logic channel_status_check_fail,
  input wire logic preamble_type_level,
  input wire logic nonaudio_level,
  input wire logic emphasis_level,
  input wire logic received_validity_flag,
  // Interrupt mask enables and request
  input wire logic [`DATA_W-1:0] err_mask,
  output logic irq_ff
);
  import rx_status_pkg::*;

  localparam int HIGH_W = RATIO_W - `DATA_W;

  // Ratio must split into a full low byte and a partial high byte
  if (RATIO_W <= `DATA_W || RATIO_W >= 2 * `DATA_W)
  begin : g_bad_ratio
    $error("RATIO_W must lie between 9 and 15");
  end
  if (PREAMBLE_W != 2 * `DATA_W)
  begin : g_bad_preamble
    $error("PREAMBLE_W must be two bytes");
  end

  logic [RATIO_W-1:0] ratio_ff;
  logic [PREAMBLE_W-1:0] pre_c_ff;
  logic [PREAMBLE_W-1:0] pre_d_ff;
  logic [`DATA_W-1:0] err_src;
  logic [`DATA_W-1:0] err_flags;
  logic [`DATA_W-1:0] err_pend;
  logic [`DATA_W-1:0] nxt_rd_data;
  logic rd_err;

  // Ratio is sampled every cycle so a read sees one coherent value per byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ratio_ff <= '0;
    else
      ratio_ff <= rate_ratio;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pre_c_ff <= '0;
    else if (!nonaudio_detected)
      pre_c_ff <= '0;
    else if (burst_c_valid)
      pre_c_ff <= burst_c_word;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pre_d_ff <= '0;
    else if (!nonaudio_detected)
      pre_d_ff <= '0;
    else if (subframe_mode)
    begin
      if (chb_c_valid)
        pre_d_ff <= chb_c_word;
    end
    else if (burst_d_valid)
      pre_d_ff <= burst_d_word;
  end

  // Sticky bits take event pulses, the rest take levels
  always_comb
  begin
    err_src = `BYTE_ZERO;
    err_src[`ERR_LOCK] = lock_level;
    err_src[`ERR_CODING] = coding_error_pulse;
    err_src[`ERR_ABSENT] = stream_absent_flag;
    err_src[`ERR_CHECK] = channel_status_check_fail;
    err_src[`ERR_PRE_TYPE] = preamble_type_level;
    err_src[`ERR_NONAUDIO] = nonaudio_level;
    err_src[`ERR_EMPHASIS] = emphasis_level;
    err_src[`ERR_VALIDITY] = received_validity_flag;
  end

  assign rd_err = rd_req && (rd_addr == `ADDR_RX_ERROR);

  for (genvar i = 0; i < `DATA_W; i++)
  begin : g_flag
    localparam flag_kind_t K = (i == `ERR_CHECK || i == `ERR_CODING) ? FLAG_STICKY : FLAG_LEVEL;
    rx_flag_cell #(
      .KIND(K)
    ) u_flag (
      .clk(clk),
      .rst(rst),
      .src_in(err_src[i]),
      .read_clear(rd_err),
      .flag_ff(err_flags[i]),
      .pend_ff(err_pend[i])
    );
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(err_pend & err_mask);
  end

  // Unmapped addresses answer zero
  always_comb
  begin
    case (rd_addr)
      `ADDR_RATIO_HIGH: nxt_rd_data = `DATA_W'(ratio_ff[RATIO_W-1:`DATA_W]);
      `ADDR_RATIO_LOW: nxt_rd_data = ratio_ff[`DATA_W-1:0];
      `ADDR_INFO_HIGH: nxt_rd_data = pre_c_ff[PREAMBLE_W-1:`DATA_W];
      `ADDR_INFO_LOW: nxt_rd_data = pre_c_ff[`DATA_W-1:0];
      `ADDR_LENGTH_HIGH: nxt_rd_data = pre_d_ff[PREAMBLE_W-1:`DATA_W];
      `ADDR_LENGTH_LOW: nxt_rd_data = pre_d_ff[`DATA_W-1:0];
      `ADDR_RX_ERROR: nxt_rd_data = err_flags;
      default: nxt_rd_data = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data_ff <= `BYTE_ZERO;
    else if (rd_req)
      rd_data_ff <= nxt_rd_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_ack_ff <= 1'b0;
    else
      rd_ack_ff <= rd_req;
  end

  chk_ratio_low_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_RATIO_LOW) |=> (rd_ack_ff && rd_data_ff == $past(ratio_ff[`DATA_W-1:0])))
    else $error("ratio low byte read wrong");

  chk_ratio_high_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_RATIO_HIGH) |=>
      (rd_ack_ff && rd_data_ff[`DATA_W-1] == 1'b0 && rd_data_ff[HIGH_W-1:0] == $past(ratio_ff[RATIO_W-1:`DATA_W])))
    else $error("ratio high byte read wrong");

  chk_info_capture:
  assert property (@(posedge clk) disable iff (rst)
    (nonaudio_detected && burst_c_valid) |=> (pre_c_ff == $past(burst_c_word)))
    else $error("burst info preamble not captured");

  chk_preamble_zero:
  assert property (@(posedge clk) disable iff (rst)
    !nonaudio_detected |=> (pre_c_ff == '0 && pre_d_ff == '0))
    else $error("preambles not zero without nonaudio");

  chk_length_capture:
  assert property (@(posedge clk) disable iff (rst)
    (nonaudio_detected && !subframe_mode && burst_d_valid) |=> (pre_d_ff == $past(burst_d_word)))
    else $error("burst length preamble not captured");

  chk_chb_load:
  assert property (@(posedge clk) disable iff (rst)
    (nonaudio_detected && subframe_mode && chb_c_valid) |=> (pre_d_ff == $past(chb_c_word)))
    else $error("channel B preamble not loaded");

  chk_check_sticky:
  assert property (@(posedge clk) disable iff (rst)
    (channel_status_check_fail || (err_flags[`ERR_CHECK] && !rd_err)) |=> err_flags[`ERR_CHECK])
    else $error("check failure flag lost before read");

  chk_absent_level:
  assert property (@(posedge clk) disable iff (rst)
    ##1 err_flags[`ERR_ABSENT] == $past(stream_absent_flag))
    else $error("stream absent flag not following input");

  chk_absent_quiet:
  assert property (@(posedge clk) disable iff (rst)
    (rd_err && stream_absent_flag == err_flags[`ERR_ABSENT]) |=>
      (!err_pend[`ERR_ABSENT] && err_flags[`ERR_ABSENT] == $past(err_flags[`ERR_ABSENT])))
    else $error("absent flag interrupts again without change");

  chk_irq_mask:
  assert property (@(posedge clk) disable iff (rst)
    ##1 irq_ff == |($past(err_pend) & $past(err_mask)))
    else $error("interrupt does not follow mask");

  chk_coding_sticky:
  assert property (@(posedge clk) disable iff (rst)
    (coding_error_pulse || (err_flags[`ERR_CODING] && !rd_err)) |=> err_flags[`ERR_CODING])
    else $error("coding error flag lost before read");

  chk_lock_level:
  assert property (@(posedge clk) disable iff (rst)
    ##1 (err_flags[`ERR_LOCK] == $past(lock_level) && err_flags[`ERR_VALIDITY] == $past(received_validity_flag)))
    else $error("lock or validity flag wrong");

  chk_read_ack_pulse:
  assert property (@(posedge clk) disable iff (rst)
    ##1 rd_ack_ff == $past(rd_req))
    else $error("read answer not one cycle after request");

  chk_read_data_hold:
  assert property (@(posedge clk) disable iff (rst)
    !rd_req |=> $stable(rd_data_ff))
    else $error("read data changed without a read");

  chk_unmapped_zero:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && (rd_addr < `ADDR_RATIO_HIGH || rd_addr > `ADDR_RX_ERROR)) |=> rd_data_ff == `BYTE_ZERO)
    else $error("unmapped address not read as zero");

  chk_info_high_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_INFO_HIGH) |=> rd_data_ff == $past(pre_c_ff[PREAMBLE_W-1:`DATA_W]))
    else $error("burst info high byte read wrong");

  chk_info_low_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_INFO_LOW) |=> rd_data_ff == $past(pre_c_ff[`DATA_W-1:0]))
    else $error("burst info low byte read wrong");

  chk_length_high_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_LENGTH_HIGH) |=> rd_data_ff == $past(pre_d_ff[PREAMBLE_W-1:`DATA_W]))
    else $error("burst length high byte read wrong");

  chk_length_low_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_LENGTH_LOW) |=> rd_data_ff == $past(pre_d_ff[`DATA_W-1:0]))
    else $error("burst length low byte read wrong");

  chk_length_subframe_hold:
  assert property (@(posedge clk) disable iff (rst)
    (nonaudio_detected && subframe_mode && !chb_c_valid) |=> $stable(pre_d_ff))
    else $error("length preamble moved without channel B load");

  chk_check_clear:
  assert property (@(posedge clk) disable iff (rst)
    (rd_err && !channel_status_check_fail) |=> !err_flags[`ERR_CHECK])
    else $error("check failure flag not cleared by read");

  chk_check_pend:
  assert property (@(posedge clk) disable iff (rst)
    channel_status_check_fail |=> err_pend[`ERR_CHECK])
    else $error("check failure did not ask for attention");

  chk_absent_notify:
  assert property (@(posedge clk) disable iff (rst)
    (stream_absent_flag != err_flags[`ERR_ABSENT]) |=> err_pend[`ERR_ABSENT])
    else $error("absent flag change not signalled");

  chk_coding_clear:
  assert property (@(posedge clk) disable iff (rst)
    (rd_err && !coding_error_pulse) |=> !err_flags[`ERR_CODING])
    else $error("coding error flag not cleared by read");

  chk_error_read:
  assert property (@(posedge clk) disable iff (rst)
    (rd_req && rd_addr == `ADDR_RX_ERROR) |=> rd_data_ff == $past(err_flags))
    else $error("error register read wrong");

endmodule : digital_rx_status_readout

/* bench/rx_source_model.sv */
// Stream source model driving the receiver-side inputs of the status bank
`timescale 1ns/1ps

module rx_source_model (
  // Clock
  input wire logic clk,
  // Preamble strobes: 0 info, 1 length, 2 channel B info
  output logic [2:0] vld,
  output logic [15:0] word,
  // Event strobes: 0 coding error, 1 check failure
  output logic [1:0] evt,
  // Condition levels by error bit position
  output logic [7:0] levels
);
  initial
  begin
    vld = 3'h0;
    word = 16'h0000;
    evt = 2'h0;
    levels = 8'h00;
  end

  // Word is inverted once its strobe drops, so a late sample is caught
  task automatic burst(input int sel, input logic [15:0] w);
    @(negedge clk);
    word = w;
    vld[sel] = 1'h1;
    @(negedge clk);
    vld = 3'h0;
    word = ~w;
  endtask : burst

  task automatic pulse(input int sel);
    @(negedge clk);
    evt[sel] = 1'h1;
    @(negedge clk);
    evt = 2'h0;
  endtask : pulse

  task automatic set_levels(input logic [7:0] v);
    @(negedge clk);
    levels = v;
  endtask : set_levels
endmodule : rx_source_model

/* bench/tb_top.sv */
// Self-checking bench of the receiver status readout
`timescale 1ns/1ps
`include "rx_status_defines.svh"

module tb_top;
  logic clk;
  logic rst;
  logic rd_req;
  logic [`ADDR_W-1:0] rd_addr;
  logic [`DATA_W-1:0] rd_data_ff;
  logic rd_ack_ff;
  logic [14:0] rate_ratio;
  logic nonaudio_detected;
  logic subframe_mode;
  logic [`DATA_W-1:0] err_mask;
  logic irq_ff;
  logic [2:0] vld;
  logic [15:0] word;
  logic [1:0] evt;
  logic [7:0] levels;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  rx_source_model src (.clk(clk), .vld(vld), .word(word), .evt(evt), .levels(levels));

  digital_rx_status_readout dut (
    .clk(clk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data_ff(rd_data_ff), .rd_ack_ff(rd_ack_ff), .rate_ratio(rate_ratio),
    .nonaudio_detected(nonaudio_detected), .subframe_mode(subframe_mode),
    .burst_c_valid(vld[0]), .burst_c_word(word), .burst_d_valid(vld[1]),
    .burst_d_word(word), .chb_c_valid(vld[2]), .chb_c_word(word),
    .lock_level(levels[0]), .coding_error_pulse(evt[0]),
    .stream_absent_flag(levels[2]), .channel_status_check_fail(evt[1]),
    .preamble_type_level(levels[4]), .nonaudio_level(levels[5]),
    .emphasis_level(levels[6]), .received_validity_flag(levels[7]),
    .err_mask(err_mask), .irq_ff(irq_ff)
  );

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Answer is due on the taking edge itself and is checked at the next falling edge
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk);
    chk("rd_ack_ff idle", 8'h00, {7'h00, rd_ack_ff});
    rd_req = 1'h1;
    rd_addr = a;
    @(negedge clk);
    rd_req = 1'h0;
    chk("rd_ack_ff", 8'h01, {7'h00, rd_ack_ff});
    chk($sformatf("reg %h", a), exp, rd_data_ff);
  endtask : rd

  task automatic t_ratio();
    @(negedge clk);
    rate_ratio = 15'h7F3C;
    rd(`ADDR_RATIO_HIGH, 8'h7F);
    rd(`ADDR_RATIO_LOW, 8'h3C);
    rate_ratio = 15'h40A5;
    rd(`ADDR_RATIO_HIGH, 8'h40);
    rd(`ADDR_RATIO_LOW, 8'hA5);
    rd(7'h11, 8'h00);
  endtask : t_ratio

  task automatic t_pre();
    @(negedge clk);
    nonaudio_detected = 1'h1;
    src.burst(0, 16'hA1B2);
    src.burst(1, 16'hC3D4);
    rd(`ADDR_INFO_HIGH, 8'hA1);
    rd(`ADDR_INFO_LOW, 8'hB2);
    rd(`ADDR_LENGTH_HIGH, 8'hC3);
    rd(`ADDR_LENGTH_LOW, 8'hD4);
    subframe_mode = 1'h1;
    src.burst(2, 16'h1357);
    src.burst(1, 16'hFFFF);
    rd(`ADDR_LENGTH_HIGH, 8'h13);
    rd(`ADDR_LENGTH_LOW, 8'h57);
    nonaudio_detected = 1'h0;
    for (int a = 20; a < 24; a++)
      rd(a[6:0], 8'h00);
  endtask : t_pre

  task automatic t_err();
    err_mask = 8'h0C;
    src.pulse(1);
    repeat (2) @(negedge clk);
    chk("irq_ff", 8'h01, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h08);
    rd(`ADDR_RX_ERROR, 8'h00);
    src.pulse(0);
    repeat (2) @(negedge clk);
    chk("irq_ff", 8'h00, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h02);
    rd(`ADDR_RX_ERROR, 8'h00);
    src.set_levels(8'h04);
    repeat (3) @(negedge clk);
    chk("irq_ff", 8'h01, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h04);
    repeat (2) @(negedge clk);
    chk("irq_ff", 8'h00, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h04);
    src.set_levels(8'hF5);
    repeat (3) @(negedge clk);
    chk("irq_ff", 8'h00, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'hF5);
    src.set_levels(8'h00);
    repeat (3) @(negedge clk);
    chk("irq_ff", 8'h01, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h00);
    // Event in the very cycle of the clearing read must survive it
    fork
      src.pulse(1);
      rd(`ADDR_RX_ERROR, 8'h00);
    join
    rd(`ADDR_RX_ERROR, 8'h08);
    err_mask = 8'hF3;
    repeat (2) @(negedge clk);
    chk("irq_ff", 8'h00, {7'h00, irq_ff});
    src.set_levels(8'h01);
    repeat (3) @(negedge clk);
    chk("irq_ff", 8'h01, {7'h00, irq_ff});
    rd(`ADDR_RX_ERROR, 8'h01);
  endtask : t_err

  initial
  begin
    rst = 1'h1;
    rd_req = 1'h0;
    rd_addr = 7'h00;
    rate_ratio = 15'h0000;
    nonaudio_detected = 1'h0;
    subframe_mode = 1'h0;
    err_mask = 8'h00;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    t_ratio();
    t_pre();
    t_err();
    give_verdict();
  end

  // Whole run needs about a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      give_verdict();
    end
  end
endmodule : tb_top
